// *** rtl/dual_temp_monitor_core.sv ***
`default_nettype none
module dual_temp_monitor_core
    import temp_mon_pkg::*;
(
    input  wire  logic                 sys_clk,
    input  wire  logic                 rst_b,
    input  wire  logic                 sleep_pin_n,
    input  wire  logic                 meas_clk,
    input  wire  logic [7:0]           meas_data,
    input  wire  logic                 open_sensor,
    input  wire  temp_mon_pkg::cfg_t    cfg,
    input  wire  temp_mon_pkg::limits_t lim,
    input  wire  logic                 status_rd,
    input  wire  logic                 alert_service,
    output logic                       meas_chan,
    output logic [7:0]                 local_value,
    output logic [7:0]                 remote_value,
    output logic [7:0]                 status,
    output logic [7:0]                 revision,
    output logic                       alarm_n_o,
    output logic                       alarm_n_oe
);
    import temp_mon_pkg::*;

    // ============================================================
    // state and derived terms
    core_state_t        s;
    core_state_t        next_s;
    logic               edge_seen;
    logic               standby;
    logic [ACC_W-1:0]   sum;
    logic [7:0]         avg;
    logic               result_due;
    logic [FLAG_W-1:0]  live;

    assign edge_seen  = s.clk_sync[1] & ~s.clk_prev;
    assign standby    = cfg.standby | ~s.sleep_sync[1];
    assign sum        = s.accum + {{(ACC_W-VALUE_W){s.data_s2[7]}}, s.data_s2};
    assign result_due = (s.st == ST_MEAS) & ~standby & edge_seen & (s.count == SAMPLE_LAST);

    // averaged, truncated toward minus; negatives clamp since the part reads no lower
    always_comb begin
        avg = sum[ACC_W-1 -: VALUE_W];
        if (avg[7]) begin
            avg = VALUE_ZERO;
        end
    end

    // comparisons wait for armed so -128 defaults do not trip when powering up running
    assign live[F_NEAR_OVER]  = s.armed & ($signed(s.local_value)  > $signed(lim.near_high));
    assign live[F_NEAR_UNDER] = s.armed & ($signed(s.local_value)  < $signed(lim.near_low));
    assign live[F_FAR_OVER]   = s.armed & ($signed(s.remote_value) > $signed(lim.far_high));
    assign live[F_FAR_UNDER]  = s.armed & ($signed(s.remote_value) < $signed(lim.far_low));
    assign live[F_OPEN]       = s.open_sync[1];

    // ============================================================
    // next state
    always_comb begin
        next_s            = s;
        next_s.clk_sync   = {s.clk_sync[0], meas_clk};
        next_s.clk_prev   = s.clk_sync[1];
        next_s.data_s1    = meas_data;
        next_s.data_s2    = s.data_s1;
        next_s.sleep_sync = {s.sleep_sync[0], sleep_pin_n};
        next_s.open_sync  = {s.open_sync[0], open_sensor};
        case (s.st)
            ST_START: begin
                next_s.start_cnt = s.start_cnt + 2'h1;
                if (s.start_cnt == START_WAIT) begin
                    if (standby) begin
                        next_s.armed = 1'b1;
                        next_s.st    = ST_SLEEP;
                    end else begin
                        next_s.st    = ST_MEAS;
                    end
                end
            end
            ST_SLEEP: begin
                next_s.accum = '0;
                next_s.count = '0;
                if (!standby) begin
                    next_s.st = ST_MEAS;
                end
            end
            ST_MEAS: begin
                if (standby) begin
                    next_s.st = ST_SLEEP;
                end else if (result_due) begin
                    if (s.chan) begin
                        next_s.remote_value  = avg;
                        next_s.stored_remote = 1'b1;
                    end else begin
                        next_s.local_value   = avg;
                        next_s.stored_local  = 1'b1;
                    end
                    next_s.chan  = ~s.chan;
                    next_s.accum = '0;
                    next_s.count = '0;
                    next_s.gap   = GAP_BASE >> cfg.rate;
                    next_s.st    = ST_GAP;
                end else if (edge_seen) begin
                    next_s.accum = sum;
                    next_s.count = s.count + 4'h1;
                end
            end
            ST_GAP: begin
                if (standby) begin
                    next_s.st = ST_SLEEP;
                end else if (edge_seen) begin
                    next_s.gap = s.gap - 8'h01;
                    if (s.gap == 8'h01) begin
                        next_s.st = ST_MEAS;
                    end
                end
            end
            default: begin
                next_s.st = ST_START;
            end
        endcase
        if (next_s.stored_local & next_s.stored_remote) begin
            next_s.armed = 1'b1;
        end
        // set beats the read-clear in the same cycle
        next_s.flags = (s.flags & ~{FLAG_W{status_rd}}) | live;
        if ((|s.flags) | (|live)) begin
            next_s.latch = 1'b1;
        end else if (alert_service) begin
            next_s.latch = 1'b0;
        end
        next_s.alarm_oe = next_s.latch & ~cfg.alarm_mask;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s              <= '0;
            s.st           <= ST_START;
            s.local_value  <= VALUE_RESET;
            s.remote_value <= VALUE_RESET;
            s.sleep_sync   <= '1;
        end else begin
            s <= next_s;
        end
    end

    // ============================================================
    // outputs
    assign meas_chan    = s.chan;
    assign local_value  = s.local_value;
    assign remote_value = s.remote_value;
    // busy covers the gap as well, since the converter keeps running there
    always_comb begin
        status                     = '0;
        status[ST_BUSY_BIT]        = (s.st == ST_MEAS) | (s.st == ST_GAP);
        status[FLAG_LSB +: FLAG_W] = s.flags;
    end
    assign revision     = {PART_CODE, DIE_STEP};
    assign alarm_n_o    = 1'b0;                                                 // open drain: only pulls low
    assign alarm_n_oe   = s.alarm_oe;

    // ============================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence pwr_sleep_seq;
        (s.st == ST_START) ##1 (s.st == ST_SLEEP);
    endsequence

    chan_toggle_a:   assert property (result_due |=> s.chan != $past(s.chan))
        else $error("channel did not alternate");
    avg_count_a:     assert property ($changed(s.local_value) |->
            $past(s.count) == SAMPLE_LAST)
        else $error("result stored before 16 samples");
    no_negative_a:   assert property ($changed(s.remote_value) |->
            !s.remote_value[7])
        else $error("negative result stored");
    sleep_hold_a:    assert property ((s.st == ST_SLEEP) [*2] |->
            $stable(s.local_value) && $stable(s.remote_value))
        else $error("value changed in standby");
    sleep_entry_a:   assert property ((s.st == ST_MEAS) && standby |=>
            s.st == ST_SLEEP)
        else $error("standby did not halt conversion");
    free_run_a:      assert property ((s.st == ST_GAP) && !standby && edge_seen
            && s.gap == 8'h01 |=> s.st == ST_MEAS)
        else $error("conversion did not restart");
    gap_load_a:      assert property (result_due |=>
            s.gap == (GAP_BASE >> $past(cfg.rate)))
        else $error("gap not loaded from rate");
    flag_clear_a:    assert property (status_rd |=> s.flags == $past(live))
        else $error("status read clear wrong");
    open_flag_a:     assert property (live[F_OPEN] |=> s.flags[F_OPEN])
        else $error("open flag not set");
    under_flag_a:    assert property (live[F_FAR_UNDER] |=> s.flags[F_FAR_UNDER])
        else $error("under flag not set");
    alarm_pull_a:    assert property ((|s.flags) && !cfg.alarm_mask |=> alarm_n_oe)
        else $error("alarm not driven");
    mask_a:          assert property (cfg.alarm_mask |=> !alarm_n_oe)
        else $error("masked alarm driven");
    latch_hold_a:    assert property (s.latch && !alert_service |=> s.latch)
        else $error("latch dropped without service");
    latch_clear_a:   assert property (alert_service && !(|s.flags) && !(|live)
            |=> !s.latch)
        else $error("latch kept after service");
    standby_arm_a:   assert property (pwr_sleep_seq |-> s.armed)
        else $error("standby power-up did not compare");
    arm_late_a:      assert property ($rose(s.armed) |->
            (s.stored_local && s.stored_remote) || $past(s.st) == ST_START)
        else $error("compare armed before both channels stored");

endmodule
`default_nettype wire

// *** rtl/temp_mon_pkg.sv ***
`default_nettype none
package temp_mon_pkg;

    // ============================================================
    // widths and counts
    localparam int          VALUE_W      = 8;
    localparam int          ACC_W        = 12;
    localparam int          FLAG_W       = 5;
    localparam logic [3:0]  SAMPLE_LAST  = 4'hf;   // 16 samples per result
    localparam logic [1:0]  START_WAIT   = 2'h3;   // lets the pin synchronisers settle
    localparam logic [7:0]  GAP_BASE     = 8'h80;  // gap in link edges, shifted right by rate

    // ============================================================
    // reset and clamp values
    localparam logic [7:0]  VALUE_RESET  = 8'h80;  // minus 128 degrees
    localparam logic [7:0]  VALUE_ZERO   = 8'h00;
    // part code and die step, values arbitrary
    localparam logic [3:0]  PART_CODE    = 4'h5;
    localparam logic [3:0]  DIE_STEP     = 4'h1;

    // ============================================================
    // status byte bit positions; flag indices are offsets from FLAG_LSB
    localparam int          ST_BUSY_BIT  = 7;
    localparam int          FLAG_LSB     = 2;
    localparam int          F_NEAR_OVER  = 4;
    localparam int          F_NEAR_UNDER = 3;
    localparam int          F_FAR_OVER   = 2;
    localparam int          F_FAR_UNDER  = 1;
    localparam int          F_OPEN       = 0;

    typedef struct packed {
        logic       alarm_mask;
        logic       standby;
        logic [2:0] rate;
    } cfg_t;

    typedef struct packed {
        logic [7:0] near_high;
        logic [7:0] near_low;
        logic [7:0] far_high;
        logic [7:0] far_low;
    } limits_t;

    typedef enum logic [3:0] {
        ST_START = 4'b0001,
        ST_SLEEP = 4'b0010,
        ST_MEAS  = 4'b0100,
        ST_GAP   = 4'b1000
    } conv_state_t;

    typedef struct packed {
        conv_state_t        st;
        logic [1:0]         start_cnt;
        logic [1:0]         clk_sync;
        logic               clk_prev;
        logic [7:0]         data_s1;
        logic [7:0]         data_s2;
        logic [1:0]         sleep_sync;
        logic [1:0]         open_sync;
        logic [ACC_W-1:0]   accum;
        logic [3:0]         count;
        logic               chan;
        logic [7:0]         local_value;
        logic [7:0]         remote_value;
        logic               stored_local;
        logic               stored_remote;
        logic               armed;
        logic [FLAG_W-1:0]  flags;
        logic               latch;
        logic               alarm_oe;
        logic [7:0]         gap;
    } core_state_t;

endpackage
`default_nettype wire

// *** sim/front_end_model.sv ***
`default_nettype none
module front_end_model (
    input  wire logic       run,
    input  wire logic [7:0] sample,
    output var  logic       meas_clk,
    output var  logic [7:0] meas_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // measurement link
    // clock stands still while not running; data moves only on the
    // falling edge so it is settled well before the next rising edge
    initial begin
        meas_clk  = 1'b0;
        meas_data = 8'h00;
        forever begin
            #80;
            if (run) begin
                meas_clk = ~meas_clk;
                if (!meas_clk) begin
                    meas_data = sample;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import temp_mon_pkg::*;
    // ============================================================
    // signals
    logic       sys_clk;
    logic       rst_b;
    logic       sleep_pin_n;
    logic       open_sensor;
    logic       status_rd;
    logic       alert_service;
    logic       run;
    logic [7:0] sample;
    cfg_t       cfg;
    limits_t    lim;
    logic       meas_clk;
    logic [7:0] meas_data;
    logic       meas_chan;
    logic [7:0] local_value;
    logic [7:0] remote_value;
    logic [7:0] status;
    logic [7:0] revision;
    logic       alarm_n_o;
    logic       alarm_n_oe;
    int         n_fail;
    int         checks_done;
    int         k;
    int         cyc;

    localparam int LINK_CYC = 8;    // 160 ns link period over the 20 ns clock

    front_end_model fe (.run(run), .sample(sample), .meas_clk(meas_clk), .meas_data(meas_data));

    dual_temp_monitor_core dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .sleep_pin_n(sleep_pin_n),
        .meas_clk(meas_clk), .meas_data(meas_data), .open_sensor(open_sensor),
        .cfg(cfg), .lim(lim), .status_rd(status_rd), .alert_service(alert_service),
        .meas_chan(meas_chan), .local_value(local_value), .remote_value(remote_value),
        .status(status), .revision(revision), .alarm_n_o(alarm_n_o),
        .alarm_n_oe(alarm_n_oe)
    );

    // ============================================================
    // tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one result is 17 link edges at the fastest rate, so 3000 cycles is ample
    task automatic wait_result();
        logic c;
        int   i;
        c = meas_chan;
        for (i = 0; i < 3000 && meas_chan === c; i++) @(posedge sys_clk);
        #1;
        if (meas_chan === c) begin
            n_fail++;
            $display("[ERR] %0t result timeout chan %h exp %h", $time, meas_chan, ~c);
            wrap_up();
        end
    endtask

    // a result takes 16 sampled edges plus the gap, each edge LINK_CYC clocks apart
    task automatic check_period(input logic [2:0] code);
        int t0;
        @(posedge sys_clk) cfg.rate <= code;
        wait_result();
        t0 = cyc;
        wait_result();
        cmp(8'(cyc - t0), 8'(LINK_CYC * (16 + (GAP_BASE >> code))), "result period");
    endtask

    // status has its own read strobe here, so no pointer write precedes it
    task automatic clear_alarm();
        @(posedge sys_clk) status_rd <= 1'b1;
        @(posedge sys_clk);
        status_rd     <= 1'b0;
        alert_service <= 1'b1;
        @(posedge sys_clk) alert_service <= 1'b0;
        ticks(3);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
    end

    // ============================================================
    // tests
    initial begin
        n_fail = 0;
        checks_done = 0;
        rst_b = 1'b0;
        sleep_pin_n = 1'b1;
        open_sensor = 1'b0;
        status_rd = 1'b0;
        alert_service = 1'b0;
        run = 1'b1;
        sample = 8'h19;
        cfg = '{alarm_mask: 1'b0, standby: 1'b0, rate: 3'h7};
        lim = '{near_high: 8'h7f, near_low: 8'hc9, far_high: 8'h7f, far_low: 8'hc9};
        ticks(3);
        cmp(local_value, 8'h80, "local reset");
        cmp(remote_value, 8'h80, "remote reset");
        cmp({4'h0, revision[7:4]}, {4'h0, PART_CODE}, "part code");
        @(posedge sys_clk) rst_b <= 1'b1;
        $display("test reset done");
        wait_result();
        cmp(local_value, 8'h19, "local first");
        cmp_bit(status[7], 1'b1, "busy");
        cmp_bit(meas_chan, 1'b1, "chan after local");
        cmp(status & 8'h7c, 8'h00, "no early compare");
        wait_result();
        cmp(remote_value, 8'h19, "remote");
        ticks(3);
        cmp(status & 8'h7c, 8'h00, "in limits");
        cmp_bit(alarm_n_oe, 1'b0, "alarm idle");
        sample <= 8'hf0;
        wait_result();
        cmp(local_value, 8'h00, "clamp local");
        wait_result();
        cmp(remote_value, 8'h00, "clamp remote");
        check_period(3'h6);
        check_period(3'h7);
        $display("test convert done");
        // high limit of minus five: only a signed compare trips on zero
        @(posedge sys_clk) lim.near_high <= 8'hfb;
        ticks(4);
        cmp(status & 8'h7c, 8'h40, "over flag");
        cmp_bit(alarm_n_oe, 1'b1, "alarm low");
        cmp_bit(alarm_n_o, 1'b0, "drive level");
        clear_alarm();
        cmp(status & 8'h7c, 8'h40, "live flag kept");
        cmp_bit(alarm_n_oe, 1'b1, "live latch kept");
        @(posedge sys_clk) cfg.alarm_mask <= 1'b1;
        ticks(3);
        cmp_bit(alarm_n_oe, 1'b0, "masked");
        @(posedge sys_clk) cfg.alarm_mask <= 1'b0;
        lim.near_high <= 8'h7f;
        ticks(3);
        cmp_bit(alarm_n_oe, 1'b1, "unmasked latch");
        @(posedge sys_clk) alert_service <= 1'b1;
        @(posedge sys_clk) alert_service <= 1'b0;
        ticks(3);
        cmp(status & 8'h7c, 8'h40, "sticky flag");
        cmp_bit(alarm_n_oe, 1'b1, "latch before read");
        clear_alarm();
        cmp(status & 8'h7c, 8'h00, "flag cleared");
        cmp_bit(alarm_n_oe, 1'b0, "latch cleared");
        @(posedge sys_clk) open_sensor <= 1'b1;
        ticks(6);
        cmp(status & 8'h7c, 8'h04, "open flag");
        @(posedge sys_clk) open_sensor <= 1'b0;
        ticks(3);
        clear_alarm();
        cmp(status & 8'h7c, 8'h00, "open cleared");
        cmp_bit(alarm_n_oe, 1'b0, "open latch cleared");
        $display("test alarm done");
        @(posedge sys_clk) cfg.standby <= 1'b1;
        ticks(2);
        sample <= 8'h2a;
        ticks(400);
        cmp(local_value, 8'h00, "hold local");
        cmp(remote_value, 8'h00, "hold remote");
        cmp_bit(status[7], 1'b0, "halted");
        @(posedge sys_clk) cfg.standby <= 1'b0;
        wait_result();
        wait_result();
        cmp(local_value, 8'h2a, "resume local");
        cmp(remote_value, 8'h2a, "resume remote");
        @(posedge sys_clk) sleep_pin_n <= 1'b0;
        ticks(2);
        sample <= 8'h33;
        ticks(400);
        cmp(local_value, 8'h2a, "pin hold");
        $display("test standby done");
        for (k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            rst_b <= 1'b0;
            sleep_pin_n <= 1'b0;
            lim.near_low <= 8'hc9;
            lim.far_low <= 8'hc9;
            ticks(3);
            @(posedge sys_clk) rst_b <= 1'b1;
            ticks(10);
            cmp(status & 8'h7c, 8'h28, "sleep start flags");
            cmp_bit(alarm_n_oe, 1'b1, "sleep start alarm");
            @(posedge sys_clk);
            if (k == 0) begin
                sleep_pin_n <= 1'b1;
                wait_result();
                wait_result();
            end else begin
                lim.near_low <= 8'h80;
                lim.far_low <= 8'h80;
            end
            clear_alarm();
            cmp(status & 8'h7c, 8'h00, "start flags cleared");
            cmp_bit(alarm_n_oe, 1'b0, "start alarm cleared");
        end
        $display("test sleep start done");
        wrap_up();
    end
endmodule
`default_nettype wire
